// File: core/startup_pkg.sv
// Purpose: Shared constants and types for the start-up and current limiter
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Serial values are five upper-case hexadecimal characters
package startup_pkg;
  // ---------------------------------------------------------------
  // Widths, full-scale and reset values
  // ---------------------------------------------------------------
  localparam int FREQ_W = 24;
  localparam int PH_W = 16;
  localparam int CUR_W = 20;
  localparam int AMP_W = 16;
  localparam int PCT_W = 7;
  localparam logic [CUR_W-1:0] CEIL_FULL = 20'hfffff;
  localparam logic [CUR_W-1:0] CEIL_RST = 20'hfffff;
  localparam logic [PH_W-1:0] PH_RST = 16'h0000;
  localparam logic [FREQ_W-1:0] SWEEP_RST = 24'h000000;
  localparam logic [AMP_W-1:0] AMP_MAX_RST = 16'hffff;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
  localparam logic [1:0] THIRD = 2'h3;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PHASE = 8'h04;
  localparam logic [7:0] OFS_SWEEP = 8'h08;
  localparam logic [7:0] OFS_CEIL = 8'h0c;
  localparam logic [7:0] OFS_PEAK = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_AMP = 8'h18;
  localparam logic [7:0] OFS_IRQ = 8'h1c;
  localparam logic [7:0] OFS_MASK = 8'h20;
  // Interrupt bit positions
  localparam int EV_SCAN = 0;
  localparam int EV_LIMIT = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_CMD = 3;
  localparam int EV_N = 4;
  // ---------------------------------------------------------------
  // Serial characters and framing
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_PCT = 8'h25;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [31:0] CMD_WORD = 32'h25303641;
  localparam logic [31:0] RSP_WORD = 32'h23303241;
  localparam logic [3:0] LEN_QUERY = 4'h4;
  localparam logic [3:0] LEN_SET = 4'h9;
  localparam logic [3:0] RSP_LAST = 4'h9;
  // Start modes
  typedef enum logic [1:0] {
    MODE_PLAIN = 2'h0,
    MODE_RESUME = 2'h1,
    MODE_SAFE = 2'h2,
    MODE_ALWAYS = 2'h3
  } start_mode_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SCAN = 4'h2,
    ST_SEEK = 4'h4,
    ST_RUN = 4'h8
  } seq_state_e;
  // Result handed back by the scan engine
  typedef struct packed {
    logic [PH_W-1:0] fs_min;
    logic [PH_W-1:0] fs_max;
    logic [FREQ_W-1:0] span;
  } scan_res_s;
endpackage

// File: core/startup_ctrl.sv
// Purpose: Start-mode sequencer, load current limiter and ceiling protocol
// Assumes: One clock, inputs synchronous, scan and seek engines outside
// Notes: Contract
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module startup_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Operator and engine handshakes
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic safety_stop,
  input wire logic run_error,
  input wire logic scan_done,
  input wire startup_pkg::scan_res_s scan_res,
  input wire logic phase_locked,
  input wire logic good_freq_stb,
  input wire logic [startup_pkg::FREQ_W-1:0] good_freq,
  output logic scan_start,
  output logic seek_start,
  output logic [startup_pkg::FREQ_W-1:0] start_freq,
  output logic [startup_pkg::PH_W-1:0] phase_setpoint,
  output logic [startup_pkg::FREQ_W-1:0] span,
  output logic power_on,
  // Current and amplitude
  input wire logic [startup_pkg::CUR_W-1:0] load_current,
  input wire logic [startup_pkg::PCT_W-1:0] amp_req,
  output logic current_clamp,
  output logic [startup_pkg::AMP_W-1:0] amp_cmd,
  // Serial byte link
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  import startup_pkg::*;

  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------
  logic [1:0] rsync_q;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rsync_q <= 2'h0;
    else rsync_q <= {rsync_q[0], 1'b1};
  end
  assign rst_n = rsync_q[1];

  // -----------------------------------------------------------------
  // Register bus
  // -----------------------------------------------------------------
  logic [1:0] mode_cfg_q;
  logic [PH_W-1:0] phase_man_q;
  logic [FREQ_W-1:0] sweep_q;
  logic [CUR_W-1:0] ceil_q, peak_q;
  logic [AMP_W-1:0] amp_min_q, amp_max_q;
  logic [EV_N-1:0] irq_st_q, irq_mask_q, ev;
  logic [31:0] rdata_d;
  logic acc, wr, rd, known, wait_q, rd_ld;
  logic ser_set;
  logic [CUR_W-1:0] ser_val;
  seq_state_e st_q;
  logic fresh_q, err_q;
  // One wait state so registered read data stands when pready is high
  assign acc = psel && penable;
  assign pready = acc && wait_q;
  assign wr = pready && pwrite;
  assign rd = pready && !pwrite;
  assign rd_ld = acc && !pwrite && !wait_q;
  assign known = (paddr <= OFS_MASK) && (paddr[1:0] == 2'h0);
  assign pslverr = pready && !known;
  // Wait-state toggle, low again after each completed access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) wait_q <= 1'b0;
    else wait_q <= acc && !wait_q;
  end
  // Read selection
  assign rdata_d =
    (paddr == OFS_CTRL) ? {30'h0, mode_cfg_q} :
    (paddr == OFS_PHASE) ? {16'h0, phase_man_q} :
    (paddr == OFS_SWEEP) ? {8'h0, sweep_q} :
    (paddr == OFS_CEIL) ? {12'h0, ceil_q} :
    (paddr == OFS_PEAK) ? {12'h0, peak_q} :
    (paddr == OFS_STAT) ? {phase_setpoint, 10'h0, err_q, fresh_q, st_q} :
    (paddr == OFS_AMP) ? {amp_max_q, amp_min_q} :
    (paddr == OFS_IRQ) ? {28'h0, irq_st_q} :
    (paddr == OFS_MASK) ? {28'h0, irq_mask_q} : 32'h0;
  // Control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_cfg_q <= 2'h0;
      phase_man_q <= PH_RST;
      sweep_q <= SWEEP_RST;
      amp_min_q <= 16'h0000;
      amp_max_q <= AMP_MAX_RST;
      irq_mask_q <= 4'h0;
      prdata <= 32'h0;
    end else begin
      if (rd_ld) prdata <= rdata_d;
      if (wr && paddr == OFS_CTRL) mode_cfg_q <= pwdata[1:0];
      if (wr && paddr == OFS_PHASE) phase_man_q <= pwdata[PH_W-1:0];
      if (wr && paddr == OFS_SWEEP) sweep_q <= pwdata[FREQ_W-1:0];
      if (wr && paddr == OFS_AMP) begin
        amp_min_q <= pwdata[15:0];
        amp_max_q <= pwdata[31:16];
      end
      if (wr && paddr == OFS_MASK) irq_mask_q <= pwdata[EV_N-1:0];
    end
  end
  // Ceiling from bus or serial set word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ceil_q <= CEIL_RST;
    else if (ser_set) ceil_q <= ser_val;
    else if (wr && paddr == OFS_CEIL) ceil_q <= pwdata[CUR_W-1:0];
  end

  // -----------------------------------------------------------------
  // Interrupts: sticky, read clears, new event wins
  // -----------------------------------------------------------------
  logic rd_irq;
  assign rd_irq = rd && paddr == OFS_IRQ;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) irq_st_q <= 4'h0;
    else irq_st_q <= (rd_irq ? 4'h0 : irq_st_q) | ev;
  end
  assign irq = |(irq_st_q & irq_mask_q);

  // -----------------------------------------------------------------
  // Start sequencer
  // -----------------------------------------------------------------
  start_mode_e mode_q;
  logic start_go, need_scan, resume_ok, good_vld_q;
  logic [FREQ_W-1:0] good_q;
  logic [PH_W-1:0] fs_diff, fs_calc;
  assign start_go = start_req && st_q == ST_IDLE;
  // Mode as it will be latched by this start
  assign need_scan = (start_mode_e'(mode_cfg_q) == MODE_ALWAYS) ||
    (start_mode_e'(mode_cfg_q) == MODE_SAFE && (fresh_q || err_q));
  assign resume_ok = start_mode_e'(mode_cfg_q) == MODE_RESUME &&
    !fresh_q && good_vld_q;
  assign fs_diff = scan_res.fs_max - scan_res.fs_min;
  assign fs_calc = scan_res.fs_min + fs_diff / PH_W'(THIRD);
  assign ev = {start_go && rx_valid && 1'b0 || ser_set,
               safety_stop, current_clamp, st_q == ST_SCAN && scan_done};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      mode_q <= MODE_PLAIN;
      fresh_q <= 1'b1;
      err_q <= 1'b0;
      scan_start <= 1'b0;
      seek_start <= 1'b0;
      start_freq <= SWEEP_RST;
      phase_setpoint <= PH_RST;
      span <= SWEEP_RST;
      good_q <= SWEEP_RST;
      good_vld_q <= 1'b0;
    end else begin
      scan_start <= 1'b0;
      seek_start <= 1'b0;
      if (safety_stop) begin
        st_q <= ST_IDLE;
        fresh_q <= 1'b1;
        err_q <= 1'b1;
      end else begin
        unique case (st_q)
          ST_IDLE: if (start_go) begin
            mode_q <= start_mode_e'(mode_cfg_q);
            start_freq <= resume_ok ? good_q : sweep_q;
            if (need_scan) begin
              st_q <= ST_SCAN;
              scan_start <= 1'b1;
            end else begin
              st_q <= ST_SEEK;
              seek_start <= 1'b1;
              if (start_mode_e'(mode_cfg_q) inside {MODE_PLAIN, MODE_RESUME})
                phase_setpoint <= phase_man_q;
            end
          end
          ST_SCAN: if (scan_done) begin
            phase_setpoint <= fs_calc;
            span <= scan_res.span;
            err_q <= 1'b0;
            st_q <= ST_SEEK;
            seek_start <= 1'b1;
            start_freq <= sweep_q;
          end
          ST_SEEK: if (phase_locked) begin
            st_q <= ST_RUN;
            fresh_q <= 1'b0;
          end
          ST_RUN: if (stop_req) st_q <= ST_IDLE;
        endcase
        // Errors of this cycle force a rescan at the next start in safe mode
        if (run_error && st_q != ST_IDLE) err_q <= 1'b1;
      end
      if (good_freq_stb && st_q == ST_RUN) begin
        good_q <= good_freq;
        good_vld_q <= 1'b1;
      end
    end
  end
  assign power_on = st_q == ST_RUN;

  // -----------------------------------------------------------------
  // Current limit, peak and amplitude scaling
  // -----------------------------------------------------------------
  logic [AMP_W-1:0] amp_diff;
  logic [AMP_W+PCT_W-1:0] amp_prod;
  logic [PCT_W-1:0] pct;
  assign current_clamp = (ceil_q != CEIL_FULL) &&
    (load_current > ceil_q);
  assign pct = (amp_req > PCT_FULL) ? PCT_FULL : amp_req;
  assign amp_diff = amp_max_q - amp_min_q;
  assign amp_prod = amp_diff * pct;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      peak_q <= 20'h0;
      amp_cmd <= 16'h0;
    end else begin
      if (wr && paddr == OFS_PEAK) peak_q <= 20'h0;
      else if (st_q != ST_IDLE && load_current > peak_q)
        peak_q <= load_current;
      amp_cmd <= amp_min_q +
        AMP_W'(amp_prod / (AMP_W+PCT_W)'(PCT_FULL));
    end
  end

  // -----------------------------------------------------------------
  // Serial ceiling protocol
  // -----------------------------------------------------------------
  logic [71:0] rx_sr_q;
  logic [3:0] rx_len_q, tx_idx_q;
  logic [CUR_W-1:0] tx_val_q;
  logic tx_busy_q, is_cr, q_ok, s_ok, hex_ok;
  logic [4:0] hex_v;
  logic [CUR_W-1:0] hex_val;
  // Per-character hex decode of the five value characters
  for (genvar i = 0; i < 5; i++) begin : g_hex
    logic [7:0] c;
    assign c = rx_sr_q[8*i +: 8];
    assign hex_v[i] = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
    assign hex_val[4*i +: 4] = (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
  end
  assign hex_ok = &hex_v;
  assign is_cr = rx_valid && rx_data == CH_CR;
  assign q_ok = rx_len_q == LEN_QUERY && rx_sr_q[31:0] == CMD_WORD;
  assign s_ok = rx_len_q == LEN_SET && rx_sr_q[71:40] == CMD_WORD && hex_ok;
  assign ser_set = is_cr && s_ok;
  assign ser_val = hex_val;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sr_q <= 72'h0;
      rx_len_q <= 4'h0;
    end else if (rx_valid) begin
      rx_sr_q <= {rx_sr_q[63:0], rx_data};
      if (rx_data == CH_PCT) rx_len_q <= 4'h1;
      else if (is_cr) rx_len_q <= 4'h0;
      else if (rx_len_q != 4'h0 && rx_len_q < 4'ha) rx_len_q <= rx_len_q + 4'h1;
    end
  end
  // Reply: response word, five hex chars, carriage return
  function automatic logic [7:0] to_hex(input logic [3:0] n);
    to_hex = (n < 4'ha) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
  endfunction
  // Next character: index plus one while tx_valid is high, else the current one
  logic [7:0] tx_ch;
  logic [3:0] tx_sel;
  assign tx_sel = tx_idx_q + {3'h0, tx_valid};
  assign tx_ch = (tx_sel < 4'h4) ? RSP_WORD[8*(3-tx_sel) +: 8] :
    (tx_sel == RSP_LAST) ? CH_CR :
    to_hex(tx_val_q[4*(8-tx_sel) +: 4]);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_q <= 1'b0;
      tx_idx_q <= 4'h0;
      tx_val_q <= 20'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h0;
    end else if (!tx_busy_q) begin
      if (is_cr && q_ok) begin
        tx_busy_q <= 1'b1;
        tx_val_q <= ceil_q;
        tx_idx_q <= 4'h0;
      end
    end else if (!tx_valid || tx_ready) begin
      if (tx_valid && tx_idx_q == RSP_LAST) begin
        tx_busy_q <= 1'b0;
        tx_valid <= 1'b0;
      end else begin
        tx_valid <= 1'b1;
        tx_data <= tx_ch;
        if (tx_valid) tx_idx_q <= tx_idx_q + 4'h1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  mode_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(start_go) |-> mode_q == $past(mode_q))
    else $error("start mode changed without a start");
  always_scan_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_go && !safety_stop && mode_cfg_q == MODE_ALWAYS |=> scan_start)
    else $error("always-scan start without scan");
  plain_sweep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_go && !safety_stop && mode_cfg_q == MODE_PLAIN
    |=> seek_start && start_freq == $past(sweep_q))
    else $error("plain start not at sweep start");
  clamp_rule_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    current_clamp == (load_current > ceil_q && ceil_q != CEIL_FULL))
    else $error("clamp does not follow ceiling");
  peak_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_q != ST_IDLE && !(wr && paddr == OFS_PEAK) |=> peak_q >= $past(load_current))
    else $error("peak missed a higher current");
  set_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ser_set |=> ceil_q == $past(hex_val))
    else $error("set word not stored");
  reply_head_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !tx_busy_q && is_cr && q_ok |-> ##2 tx_valid && tx_data == CH_HASH)
    else $error("reply does not open with response word");
  third_calc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_q == ST_SCAN && scan_done && !safety_stop |=> phase_setpoint == $past(fs_calc)
    && seek_start)
    else $error("setpoint not taken from scan");
endmodule

// File: verification/ceil_host.sv
// Purpose: Serial host model that sends ceiling words and gathers replies
// Assumes: One byte per cycle, driven just after a rising edge
// Notes: Idle data shows the inverse of the last byte sent
`timescale 1ns/10ps
module ceil_host (
  // Clock
  input wire logic ref_clk,
  // Byte link
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Stall control
  input wire logic slow
);
  logic [7:0] reply[$];

  // Send one word, terminated by carriage return
  task automatic send(input string s);
    @(posedge ref_clk);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_data <= s[i];
      @(posedge ref_clk);
    end
    rx_data <= 8'h0d;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_data <= 8'hf2;
  endtask

  // Idle levels at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  // Gather reply bytes, stalling every other cycle when slow
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready)
      reply.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule

// File: verification/testbench.sv
// Purpose: Self-checking bench for start modes and current ceiling
// Assumes: One-wait-state APB, serial host model on the byte link
// Notes: Each scenario is one task that checks its own results
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  miscompares++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import startup_pkg::*;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, rx_data, tx_data;
  logic [31:0] pwdata, prdata, rd_q;
  logic start_req, stop_req, safety_stop, run_error, scan_done;
  logic phase_locked, good_freq_stb, scan_start, seek_start, power_on;
  logic [FREQ_W-1:0] good_freq, start_freq, span;
  logic [PH_W-1:0] phase_setpoint;
  logic [CUR_W-1:0] load_current;
  logic [PCT_W-1:0] amp_req;
  logic [AMP_W-1:0] amp_cmd;
  logic current_clamp, rx_valid, tx_valid, tx_ready, slow, err_q;
  scan_res_s scan_res;
  int miscompares = 0;
  int check_count = 0;

  startup_ctrl u_startup_ctrl (.ref_clk(ref_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .start_req(start_req), .stop_req(stop_req),
    .safety_stop(safety_stop), .run_error(run_error),
    .scan_done(scan_done), .scan_res(scan_res),
    .phase_locked(phase_locked), .good_freq_stb(good_freq_stb),
    .good_freq(good_freq), .scan_start(scan_start),
    .seek_start(seek_start), .start_freq(start_freq),
    .phase_setpoint(phase_setpoint), .span(span), .power_on(power_on),
    .load_current(load_current), .amp_req(amp_req),
    .current_clamp(current_clamp), .amp_cmd(amp_cmd),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  ceil_host u_ceil_host (.ref_clk(ref_clk), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .slow(slow));

  // -------------------------------------------------------------
  // Bus and event tasks
  // -------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h00000000);
    `CHK(rd_q, e)
  endtask

  // One-cycle pulse of lock, error, safety stop or stop
  task automatic ev(input logic [3:0] k);
    @(posedge ref_clk);
    {phase_locked, run_error, safety_stop, stop_req} <= k;
    @(posedge ref_clk);
    {phase_locked, run_error, safety_stop, stop_req} <= 4'h0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic go(input logic sc);
    int n;
    n = 0;
    @(posedge ref_clk);
    start_req <= 1'b1;
    @(posedge ref_clk);
    start_req <= 1'b0;
    #1;
    while ((scan_start | seek_start) !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(scan_start, sc)
    `CHK(seek_start, ~sc)
  endtask

  task automatic scan_fin(input logic [15:0] mn, input logic [15:0] mx,
                          input logic [23:0] sp);
    int n;
    n = 0;
    @(posedge ref_clk);
    scan_res <= {mn, mx, sp};
    scan_done <= 1'b1;
    @(posedge ref_clk);
    scan_done <= 1'b0;
    scan_res <= ~{mn, mx, sp};
    #1;
    while (seek_start !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(seek_start, 1'b1)
  endtask

  task automatic amp(input logic [6:0] p, input logic [15:0] e);
    @(posedge ref_clk);
    amp_req <= p;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(amp_cmd, e)
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_regs();
    chk_rd(OFS_CEIL, {12'h000, CEIL_RST});
    chk_rd(OFS_CTRL, 32'h00000000);
    chk_rd(8'h24, 32'h00000000);
    `CHK(err_q, 1'b1)
  endtask

  task automatic t_resume();
    apb(OFS_CTRL, 1'b1, 32'h00000001);
    apb(OFS_PHASE, 1'b1, 32'h00001234);
    apb(OFS_SWEEP, 1'b1, 32'h000a0000);
    go(1'b0);
    `CHK(start_freq, 24'h0a0000)
    `CHK(phase_setpoint, 16'h1234)
    ev(4'h8);
    `CHK(power_on, 1'b1)
    @(posedge ref_clk);
    good_freq <= 24'h0b1111;
    good_freq_stb <= 1'b1;
    @(posedge ref_clk);
    good_freq <= 24'hf4eeee;
    good_freq_stb <= 1'b0;
    ev(4'h1);
    go(1'b0);
    `CHK(start_freq, 24'h0b1111)
    ev(4'h8);
    ev(4'h2);
    go(1'b0);
    `CHK(start_freq, 24'h0a0000)
    ev(4'h8);
    ev(4'h1);
  endtask

  task automatic t_plain();
    apb(OFS_CTRL, 1'b1, 32'h00000000);
    apb(OFS_PHASE, 1'b1, 32'h00000777);
    go(1'b0);
    `CHK(start_freq, 24'h0a0000)
    `CHK(phase_setpoint, 16'h0777)
    ev(4'h8);
    apb(OFS_CTRL, 1'b1, 32'h00000003);
    repeat (3) @(posedge ref_clk);
    `CHK(power_on, 1'b1)
    `CHK(phase_setpoint, 16'h0777)
    ev(4'h1);
  endtask

  task automatic t_always();
    apb(OFS_IRQ, 1'b0, 32'h00000000);
    apb(OFS_MASK, 1'b1, 32'h00000001);
    go(1'b1);
    `CHK(start_freq, 24'h0a0000)
    scan_fin(16'h0100, 16'h0400, 24'h000500);
    `CHK(phase_setpoint, 16'h0200)
    `CHK(span, 24'h000500)
    `CHK(irq, 1'b1)
    chk_rd(OFS_IRQ, 32'h00000001);
    #1;
    `CHK(irq, 1'b0)
    ev(4'h8);
    `CHK(power_on, 1'b1)
    ev(4'h1);
    go(1'b1);
    scan_fin(16'h0000, 16'h0010, 24'h000100);
    `CHK(phase_setpoint, 16'h0005)
    ev(4'h8);
    ev(4'h1);
  endtask

  task automatic t_safe();
    apb(OFS_CTRL, 1'b1, 32'h00000002);
    ev(4'h2);
    go(1'b1);
    scan_fin(16'h0300, 16'h0600, 24'h000200);
    `CHK(phase_setpoint, 16'h0400)
    `CHK(span, 24'h000200)
    ev(4'h8);
    ev(4'h1);
    go(1'b0);
    `CHK(start_freq, 24'h0a0000)
    `CHK(phase_setpoint, 16'h0400)
    ev(4'h8);
    ev(4'h4);
    ev(4'h1);
    go(1'b1);
    scan_fin(16'h0300, 16'h0600, 24'h000200);
    ev(4'h8);
  endtask

  task automatic t_limit();
    string e;
    int n;
    e = "#02A00100";
    n = 0;
    apb(OFS_PEAK, 1'b1, 32'h00000000);
    u_ceil_host.send("%06A00100");
    chk_rd(OFS_CEIL, 32'h00000100);
    @(posedge ref_clk);
    load_current <= 20'h00200;
    @(posedge ref_clk);
    #1;
    `CHK(current_clamp, 1'b1)
    load_current <= 20'h00100;
    @(posedge ref_clk);
    #1;
    `CHK(current_clamp, 1'b0)
    chk_rd(OFS_PEAK, 32'h00000200);
    slow <= 1'b1;
    u_ceil_host.send("%06A");
    while (u_ceil_host.reply.size() < 10 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(u_ceil_host.reply.size(), 10)
    for (int i = 0; i < 9; i++)
      `CHK(u_ceil_host.reply[i], e[i])
    `CHK(u_ceil_host.reply[9], 8'h0d)
    apb(OFS_CEIL, 1'b1, 32'h000fffff);
    load_current <= 20'hfffff;
    @(posedge ref_clk);
    #1;
    `CHK(current_clamp, 1'b0)
    ev(4'h1);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {start_req, stop_req, safety_stop, run_error, scan_done} = 5'h00;
    {phase_locked, good_freq_stb, good_freq, scan_res} = '0;
    {load_current, amp_req, slow} = '0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_resume();
    t_plain();
    t_always();
    t_safe();
    t_limit();
    apb(OFS_AMP, 1'b1, 32'h30001000);
    amp(7'h32, 16'h2000);
    amp(7'h64, 16'h3000);
    amp(7'h00, 16'h1000);
    give_verdict();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
